// File: design/srl_top.sv
// Comparator set-reset latch with APB control and pin output muxes
`timescale 1ns/1ps
`default_nettype none
module srl_top (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire srl_pkg::srl_apb_req_t apbReq,
   output srl_pkg::srl_apb_rsp_t apbRsp,
   input wire logic [srl_pkg::NCMP-1:0] cmpOutput,
   input wire logic [srl_pkg::NCMP-1:0] cmpPinOutputEnable,
   input wire logic [srl_pkg::NCMP-1:0] pinDirectionBits,
   output srl_pkg::srl_pins_t pins,
   output logic latchQ
);
   import srl_pkg::*;

   typedef struct packed {
      srl_ctrl_t ctrl;
      logic softSet;
      logic softRst;
      srl_latch_t latch;
      srl_pins_t pins;
      srl_apb_rsp_t rsp;
   } srl_state_t;

   srl_state_t st;
   srl_state_t next_st;
   logic [NCMP-1:0] cmpSync;
   logic [NCMP-1:0] muxSel;
   logic q;
   logic setIn;
   logic rstIn;
   logic access;
   logic done;
   logic hitCtrl;
   logic hitStat;
   logic [DATA_W-1:0] readValue;

   // Comparator levels come from another domain
   srl_sync u_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .async(cmpOutput),
      .synced(cmpSync)
   );

   // Pin path selection
   srl_outmux u_mux (
      .cfg(st.ctrl.cfg),
      .cmp(cmpSync),
      .q(q),
      .sel(muxSel)
   );

   // Latch inputs, pulses and gated comparators
   assign q = (st.latch == LATCH_SET);
   assign setIn = st.softSet | (st.ctrl.setEn & cmpSync[CMP1]);
   assign rstIn = st.softRst | (st.ctrl.rstEn & cmpSync[CMP2]);

   // Bus phase decode
   assign access = apbReq.psel & apbReq.penable;
   assign done = access & st.rsp.pready;
   assign hitCtrl = (apbReq.paddr == ADDR_CTRL);
   assign hitStat = (apbReq.paddr == ADDR_STAT);

   // Read data mux; low control bits always read zero
   always_comb begin
      readValue = DATA_ZERO;
      if (hitCtrl) begin
         readValue[BIT_CFG_LO+1:BIT_CFG_LO] = st.ctrl.cfg;
         readValue[BIT_SET_EN] = st.ctrl.setEn;
         readValue[BIT_RST_EN] = st.ctrl.rstEn;
      end else if (hitStat) begin
         readValue[STAT_Q] = q;
         readValue[STAT_CMP1] = cmpSync[CMP1];
         readValue[STAT_CMP2] = cmpSync[CMP2];
      end
   end

   // Next state of the whole block
   always_comb begin
      next_st = st;
      // One wait state, then the answer
      next_st.rsp.pready = access & ~st.rsp.pready;
      next_st.rsp.prdata = DATA_ZERO;
      next_st.rsp.pslverr = 1'b0;
      if (access & ~st.rsp.pready) begin
         next_st.rsp.prdata = apbReq.pwrite ? DATA_ZERO : readValue;
         next_st.rsp.pslverr = ~(hitCtrl | hitStat);
      end
      // Pulse bits clear one cycle after they fire
      next_st.softSet = 1'b0;
      next_st.softRst = 1'b0;
      if (done & apbReq.pwrite & hitCtrl) begin
         next_st.ctrl.cfg =
            srl_cfg_t'(apbReq.pwdata[BIT_CFG_LO+1:BIT_CFG_LO]);
         next_st.ctrl.setEn = apbReq.pwdata[BIT_SET_EN];
         next_st.ctrl.rstEn = apbReq.pwdata[BIT_RST_EN];
         next_st.softSet = apbReq.pwdata[BIT_SOFT_SET];
         next_st.softRst = apbReq.pwdata[BIT_SOFT_RST];
      end
      // Latch update, reset wins
      case (st.latch)
         LATCH_CLR: begin
            if (setIn & ~rstIn) begin
               next_st.latch = LATCH_SET;
            end
         end
         LATCH_SET: begin
            if (rstIn) begin
               next_st.latch = LATCH_CLR;
            end
         end
         default: begin
            next_st.latch = LATCH_CLR;
         end
      endcase
      // Pin levels and drivers
      next_st.pins.level = muxSel;
      next_st.pins.oe = cmpPinOutputEnable & ~pinDirectionBits;
   end

   // State register with synchronous reset
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         st.ctrl <= CTRL_RESET;
         st.softSet <= 1'b0;
         st.softRst <= 1'b0;
         st.latch <= LATCH_CLR;
         st.pins.level <= PINS_OFF;
         st.pins.oe <= PINS_OFF;
         st.rsp <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Bus and pin outputs straight from flops, latchQ decoded from the latch state
   assign apbRsp = st.rsp;
   assign pins = st.pins;
   assign latchQ = q;

   // Checks on the block's own behaviour
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   a_reset_raw_cfg: assert property (
      !$past(rstn) |-> (st.ctrl.cfg == CFG_RAW && !q))
      else $error("config not raw after reset");

   a_raw_both_pins: assert property (
      st.ctrl.cfg == CFG_RAW |=> pins.level == $past(cmpSync))
      else $error("raw mode does not pass comparators");

   a_pin1_direct: assert property (
      !st.ctrl.cfg[0] |=> pins.level[CMP1] == $past(cmpSync[CMP1]))
      else $error("pin 1 not comparator 1");

   a_pin1_latch_q: assert property (
      st.ctrl.cfg[0] |=> pins.level[CMP1] == $past(q))
      else $error("pin 1 not latch Q");

   a_pin2_select: assert property (
      st.ctrl.cfg[1] |=> pins.level[CMP2] == !$past(q))
      else $error("pin 2 not inverted Q");

   a_q_qn_mode: assert property (
      st.ctrl.cfg == CFG_Q_QN ##1 st.ctrl.cfg == CFG_Q_QN
      |-> pins.level[CMP1] != pins.level[CMP2])
      else $error("Q and inverted Q not opposite");

   a_oe_gate: assert property (
      rstn |=> pins.oe ==
         $past(cmpPinOutputEnable & ~pinDirectionBits))
      else $error("pin enable wrong");

   a_reset_dominant: assert property (
      setIn && rstIn |=> !q)
      else $error("set won over reset");

   a_cmp_sets: assert property (
      st.ctrl.setEn && cmpOutput[CMP1] && !st.ctrl.rstEn
      && !st.softRst [*4] |-> q)
      else $error("comparator 1 did not set latch");

   a_cmp_resets: assert property (
      st.ctrl.rstEn && cmpSync[CMP2] |=> !q)
      else $error("comparator 2 did not reset latch");

   a_no_influence: assert property (
      !setIn && !rstIn |=> $stable(q))
      else $error("latch moved without input");

   a_pulse_once: assert property (
      done && apbReq.pwrite && hitCtrl && apbReq.pwdata[BIT_SOFT_SET]
      |=> st.softSet ##1 !st.softSet)
      else $error("soft set pulse not single");

   a_low_bits_zero: assert property (
      done && !apbReq.pwrite && hitCtrl
      |-> apbRsp.prdata[BIT_SOFT_SET:0] == '0)
      else $error("low control bits not zero");

   a_cfg_write: assert property (
      done && apbReq.pwrite && hitCtrl
      |=> st.ctrl.cfg == $past(apbReq.pwdata[BIT_CFG_LO+1:BIT_CFG_LO]))
      else $error("config field not stored");

   a_soft_sets: assert property (
      st.softSet && !rstIn |=> q)
      else $error("soft set pulse did not set latch");

   a_reset_pulse_once: assert property (
      done && apbReq.pwrite && hitCtrl && apbReq.pwdata[BIT_SOFT_RST]
      |=> st.softRst ##1 !st.softRst)
      else $error("soft reset pulse not single");

   a_set_ignored: assert property (
      !st.ctrl.setEn && !st.softSet && !q |=> !q)
      else $error("latch set with set path off");

   a_rst_ignored: assert property (
      !st.ctrl.rstEn && !st.softRst && q |=> q)
      else $error("latch reset with reset path off");

   // Main scenarios
   c_cmp_set: cover property (
      st.ctrl.setEn && cmpSync[CMP1] ##1 q);
   c_soft_reset: cover property (
      q && st.softRst ##1 !q);
   c_q_qn: cover property (
      st.ctrl.cfg == CFG_Q_QN && pins.oe == '1);
   c_unmapped: cover property (
      done && apbRsp.pslverr);
endmodule
`default_nettype wire

// File: pkg/srl_pkg.sv
// Constants and carrier types for the comparator latch and output mux
//
// Notes on behaviour
// - The two-bit configuration field steers both comparator pin paths.
// - After any reset the pins carry the raw comparator outputs.
// - A pin is driven only while its comparator output enable is set.
// - The output selection ignores whether the comparators are enabled.
// - Upper config bit 1 puts latch inverted Q on pin 2, else comp 2.
// - Lower config bit 0 puts latch Q on pin 1, else comp 1.
// - With set enable high, a high comparator 1 output sets the latch.
// - Control bits power up as 0 and the four lowest bits read as 0.
// - With set and reset both high the latch goes to reset.
// - With reset enable high, a high comparator 2 output resets it.
// - A software pulse bit fires one pulse and then clears itself.
package srl_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CTRL_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
   localparam int BIT_CFG_LO = 6;
   localparam int BIT_SET_EN = 5;
   localparam int BIT_RST_EN = 4;
   localparam int BIT_SOFT_SET = 3;
   localparam int BIT_SOFT_RST = 2;
   localparam int STAT_Q = 0;
   localparam int STAT_CMP1 = 1;
   localparam int STAT_CMP2 = 2;
   localparam int CMP1 = 0;
   localparam int CMP2 = 1;
   localparam int NCMP = 2;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
   localparam logic [1:0] PINS_OFF = 2'h0;

   // Output mux modes, low bit steers pin 1, high bit pin 2
   typedef enum logic [1:0] {
      CFG_RAW = 2'h0,
      CFG_Q_C2 = 2'h1,
      CFG_C1_QN = 2'h2,
      CFG_Q_QN = 2'h3
   } srl_cfg_t;

   // One-hot latch state
   typedef enum logic [1:0] {
      LATCH_CLR = 2'b01,
      LATCH_SET = 2'b10
   } srl_latch_t;

   typedef struct packed {
      srl_cfg_t cfg;
      logic setEn;
      logic rstEn;
   } srl_ctrl_t;

   localparam srl_ctrl_t CTRL_RESET = '{cfg: CFG_RAW, setEn: 1'b0,
                                        rstEn: 1'b0};

   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [DATA_W-1:0] pwdata;
   } srl_apb_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } srl_apb_rsp_t;

   typedef struct packed {
      logic [NCMP-1:0] level;
      logic [NCMP-1:0] oe;
   } srl_pins_t;
endpackage

// File: design/srl_sync.sv
// Two-stage synchroniser for the asynchronous comparator outputs
`timescale 1ns/1ps
`default_nettype none
module srl_sync (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [srl_pkg::NCMP-1:0] async,
   output logic [srl_pkg::NCMP-1:0] synced
);
   import srl_pkg::*;

   typedef struct packed {
      logic [NCMP-1:0] stage1;
      logic [NCMP-1:0] stage2;
   } srl_sync_st_t;

   srl_sync_st_t st;
   srl_sync_st_t next_st;

   // First stage feeds only the second
   always_comb begin
      next_st.stage1 = async;
      next_st.stage2 = st.stage1;
   end

   // Registered stages, cleared in reset
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign synced = st.stage2;
endmodule
`default_nettype wire

// File: design/srl_outmux.sv
// Output multiplexer choosing comparator or latch levels per pin
`timescale 1ns/1ps
`default_nettype none
module srl_outmux (
   input wire srl_pkg::srl_cfg_t cfg,
   input wire logic [srl_pkg::NCMP-1:0] cmp,
   input wire logic q,
   output logic [srl_pkg::NCMP-1:0] sel
);
   import srl_pkg::*;

   // Mode decode; comparator enables are not looked at
   always_comb begin
      sel = cmp;
      case (cfg)
         CFG_RAW: begin
            sel = cmp;
         end
         CFG_Q_C2: begin
            sel[CMP1] = q;
            sel[CMP2] = cmp[CMP2];
         end
         CFG_C1_QN: begin
            sel[CMP1] = cmp[CMP1];
            sel[CMP2] = ~q;
         end
         CFG_Q_QN: begin
            sel[CMP1] = q;
            sel[CMP2] = ~q;
         end
         default: begin
            sel = cmp;
         end
      endcase
   end
endmodule
`default_nettype wire

// File: test/srl_partner.sv
// Comparator and port pin model facing the latch block
`timescale 1ns/1ps
`default_nettype none
module srl_partner (
   input wire logic [1:0] cmpWant,
   input wire logic [1:0] oeWant,
   input wire logic [1:0] dirWant,
   output logic [1:0] cmpOutput,
   output logic [1:0] cmpPinOutputEnable,
   output logic [1:0] pinDirectionBits
);
   // Comparator levels and software pin settings
   assign cmpOutput = cmpWant;
   assign cmpPinOutputEnable = oeWant;
   assign pinDirectionBits = dirWant;
endmodule
`default_nettype wire

// File: test/srl_top_test.sv
// Self-checking bench for the comparator latch and output mux
`timescale 1ns/1ps
`default_nettype none
module srl_top_test import srl_pkg::*;;
   logic ref_clk;
   logic rstn;
   srl_apb_req_t req;
   srl_apb_rsp_t apbRsp;
   srl_pins_t pins;
   logic latchQ;
   logic [1:0] cmpW, oeW, dirW, cmpO, oeO, dirO;
   logic [31:0] rdat;
   logic err;
   int nErrors, cmpCount, cyc;

   srl_partner i_partner (.cmpWant(cmpW), .oeWant(oeW), .dirWant(dirW),
      .cmpOutput(cmpO), .cmpPinOutputEnable(oeO), .pinDirectionBits(dirO));
   srl_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .apbReq(req),
      .apbRsp(apbRsp), .cmpOutput(cmpO), .cmpPinOutputEnable(oeO),
      .pinDirectionBits(dirO), .pins(pins), .latchQ(latchQ));

   // Clock of 4 ns
   always #2 ref_clk = ~ref_clk;

   // Hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         nErrors++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
      if (nErrors == 0 && cmpCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] s, input logic [31:0] x);
      cmpCount++;
      if (s !== x) begin
         nErrors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= w;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge ref_clk);
      req.penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (apbRsp.pready !== 1'b1);
      rdat = apbRsp.prdata;
      err = apbRsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Reset state and register access kinds
   task automatic t_regs();
      cmpW <= 2'h2;
      tick(5);
      check(pins.level, 32'h2);
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(rdat, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(rdat, 32'hF0);
      apb(1'b0, 8'h08, 32'h0);
      check(err, 32'h1);
      check(rdat, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h0);
      // Status: comparator 2 high, latch clear
      apb(1'b0, ADDR_STAT, 32'h0);
      check(rdat, 32'h4);
      check(err, 32'h0);
   endtask

   // Every mux mode against every comparator pattern and latch state
   task automatic t_mux();
      logic [3:0] k;
      logic q;
      for (int i = 0; i < 32; i++) begin
         k = i[3:0];
         q = i[4];
         apb(1'b1, ADDR_CTRL, {24'h0, k[3:2], 2'h0, q, ~q, 2'h0});
         cmpW <= k[1:0];
         tick(6);
         check(latchQ, q);
         check(pins.level[0], k[2] ? q : k[0]);
         check(pins.level[1], k[3] ? !q : k[1]);
      end
   endtask

   // Comparator set and reset through the enables
   task automatic t_setrst();
      logic [9:0] seq;
      logic [4:0] exq;
      seq = 10'b01_00_10_01_11;
      exq = 5'b11010;
      apb(1'b1, ADDR_CTRL, 32'h30);
      for (int i = 4; i >= 0; i--) begin
         cmpW <= seq[2*i+:2];
         tick(5);
         check(latchQ, exq[i]);
      end
      // Set enable alone: comparator 1 sets, comparator 2 ignored
      apb(1'b1, ADDR_CTRL, 32'h20);
      tick(2);
      check(latchQ, 1'b1);
      // Both pulses at once on a set latch
      apb(1'b1, ADDR_CTRL, 32'h0C);
      tick(2);
      check(latchQ, 1'b0);
   endtask

   // Pin drive enables from output enable and direction
   task automatic t_oe();
      logic [3:0] k;
      apb(1'b1, ADDR_CTRL, 32'hC8);
      for (int i = 0; i < 16; i++) begin
         k = i[3:0];
         oeW <= k[1:0];
         dirW <= k[3:2];
         tick(3);
         check(pins.oe, k[1:0] & ~k[3:2]);
         check(pins.level, 32'h1);
      end
   endtask

   // Reset in mid-run returns the pins to raw comparator levels
   task automatic t_rst();
      cmpW <= 2'h2;
      rstn <= 1'b0;
      tick(2);
      rstn <= 1'b1;
      tick(4);
      check(pins.level, 32'h2);
      check(latchQ, 1'b0);
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(rdat, 32'h0);
   endtask

   // Main sequence
   initial begin
      ref_clk = 1'b0;
      rstn = 1'b0;
      req = '0;
      cmpW = 2'h0;
      oeW = 2'h0;
      dirW = 2'h3;
      nErrors = 0;
      cmpCount = 0;
      cyc = 0;
      tick(12);
      rstn <= 1'b1;
      tick(1);
      t_regs();
      t_mux();
      t_setrst();
      t_oe();
      t_rst();
      end_sim();
   end
endmodule
`default_nettype wire
